// [hdl/isf_pkg.sv]
// Purpose: Shared constants and types for the sample frame transmitter
// Assumes: 50 MHz system clock
// Notes: Register map is local to this block
package isf_pkg;
	localparam int unsigned CLK_HZ = 50000000;
	localparam int unsigned BAUD_DEFAULT = 460800;
	localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_DEFAULT;
	localparam int unsigned SAMPLE_HZ = 800;
	localparam int unsigned SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
	localparam int unsigned COMP_CYCLES = 64;
	localparam logic [15:0] DECIM_DEFAULT = 16'h0004;
	localparam logic [2:0] FILTER_DEFAULT = 3'h2;
	localparam logic [2:0] ACCEL_RANGE_DEFAULT = 3'h0;
	localparam logic [2:0] GYRO_RANGE_DEFAULT = 3'h0;
	localparam logic [1:0] SELECT_DEFAULT = 2'h3;
	localparam logic [7:0] MARKER_BYTE = 8'ha5;
	localparam logic [7:0] MSG_TYPE = 8'ha2;
	localparam logic [7:0] ACCEL_CODE = 8'h81;
	localparam logic [7:0] RATE_CODE = 8'h82;
	localparam logic [7:0] VEC_SIZE = 8'h0c;
	localparam logic [7:0] FIELD_LEN = 8'h0e;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_DECIM = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_FILTER = 4'h3;
	localparam logic [3:0] REG_RANGE = 4'h4;
	localparam int CTRL_TRIG_EN = 0;
	localparam int CTRL_SEL_ACCEL = 1;
	localparam int CTRL_SEL_RATE = 2;

	typedef struct packed {
		logic [95:0] accel;
		logic [95:0] rate;
	} isf_sample_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} isf_bus_t;

	typedef enum logic [3:0] {
		TX_IDLE = 4'b0001,
		TX_START = 4'b0010,
		TX_DATA = 4'b0100,
		TX_STOP = 4'b1000
	} isf_tx_t;
endpackage

// [hdl/isf_frame_tx.sv]
// Purpose: Samples sensors at a fixed rate and frames samples onto the serial link
// Assumes: Sensor words arrive on sensorIn, already compensated by upstream logic
// Notes: Command decoding is outside; software sets mode through the register port
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
module isf_frame_tx import isf_pkg::*; #(
	parameter int unsigned SAMPLE_PERIOD = SAMPLE_CYCLES,
	parameter int unsigned BIT_PERIOD = BIT_CYCLES
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire isf_bus_t busIn,
	output logic [31:0] rdata,
	input wire isf_sample_t sensorIn,
	input wire logic serial_rx_pos,
	input wire logic serial_rx_neg,
	output logic serialTxPos,
	output logic serialTxNeg,
	output logic rxLevel,
	output logic sample_valid_strobe,
	input wire logic ext_sample_request_in,
	input wire logic gps_second_pulse_in,
	output logic ppsSeen
);
	localparam int unsigned SP_W = $clog2(SAMPLE_PERIOD + 1);
	localparam int unsigned BP_W = $clog2(BIT_PERIOD + 1);

	// Fletcher step, modulo 255
	function automatic logic [7:0] mod255(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		if (s >= 9'd255)
			s = s - 9'd255;
		return s[7:0];
	endfunction

	logic trigEn;
	logic [1:0] select;
	logic [15:0] decim;
	logic [2:0] filterSel;
	logic [2:0] accelRange;
	logic [2:0] gyroRange;
	logic [SP_W-1:0] sampleCnt;
	logic sampleTick;
	logic [15:0] decimCnt;
	logic [6:0] compCnt;
	logic compDone;
	isf_sample_t latest;
	isf_sample_t frame;
	logic [2:0] trigSync;
	logic [2:0] ppsSync;
	logic [2:0] rxpSync;
	logic [2:0] rxnSync;
	logic trigLevel;
	logic ppsLevel;
	logic trigPrev;
	logic trigRise;
	logic sendReq;
	logic [5:0] byteIdx;
	logic [5:0] frameLen;
	logic [7:0] curByte;
	logic [7:0] sumA;
	logic [7:0] sumB;
	logic busy;
	isf_tx_t txState;
	logic [BP_W-1:0] bitCnt;
	logic [2:0] bitIdx;
	logic [7:0] shiftReg;
	logic txLine;
	logic byteDone;

	// Software-visible configuration
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			trigEn <= 1'b0;
			select <= SELECT_DEFAULT;
			decim <= DECIM_DEFAULT;
			filterSel <= FILTER_DEFAULT;
			accelRange <= ACCEL_RANGE_DEFAULT;
			gyroRange <= GYRO_RANGE_DEFAULT;
		end else if (busIn.wr) begin
			case (busIn.addr)
				REG_CTRL: begin
					trigEn <= busIn.wdata[CTRL_TRIG_EN];
					select <= {busIn.wdata[CTRL_SEL_RATE], busIn.wdata[CTRL_SEL_ACCEL]};
				end
				REG_DECIM: decim <= busIn.wdata[15:0];
				REG_FILTER: filterSel <= busIn.wdata[2:0];
				REG_RANGE: begin
					accelRange <= busIn.wdata[2:0];
					gyroRange <= busIn.wdata[6:4];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst)
			rdata <= 32'h0;
		else if (busIn.rd) begin
			case (busIn.addr)
				REG_CTRL: rdata <= {29'h0, select[1], select[0], trigEn};
				REG_DECIM: rdata <= {16'h0, decim};
				REG_STATUS: rdata <= {26'h0, byteIdx};
				REG_FILTER: rdata <= {29'h0, filterSel};
				REG_RANGE: rdata <= {25'h0, gyroRange, 1'b0, accelRange};
				default: rdata <= 32'h0;
			endcase
		end else
			rdata <= 32'h0;
	end

	// Three-stage synchronisers; a change counts once stages two and three agree, and for the rx pair once the two lines also differ
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			trigSync <= 3'h0;
			ppsSync <= 3'h0;
			rxpSync <= 3'h7;
			rxnSync <= 3'h0;
			trigLevel <= 1'b0;
			ppsLevel <= 1'b0;
			rxLevel <= 1'b1;
			trigPrev <= 1'b0;
		end else begin
			trigSync <= {trigSync[1:0], ext_sample_request_in};
			ppsSync <= {ppsSync[1:0], gps_second_pulse_in};
			rxpSync <= {rxpSync[1:0], serial_rx_pos};
			rxnSync <= {rxnSync[1:0], serial_rx_neg};
			trigPrev <= trigLevel;
			if (trigSync[1] == trigSync[2])
				trigLevel <= trigSync[2];
			if (ppsSync[1] == ppsSync[2])
				ppsLevel <= ppsSync[2];
			if (rxpSync[1] == rxpSync[2] && rxnSync[1] == rxnSync[2] && rxpSync[2] != rxnSync[2])
				rxLevel <= rxpSync[2];
		end
	end

	// Sticky until reset; the pulse itself only marks a second here
	always_ff @(posedge mclk) begin
		if (sys_rst)
			ppsSeen <= 1'b0;
		else if (ppsLevel)
			ppsSeen <= 1'b1;
	end

	// Fixed internal sample clock, independent of the output rate
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sampleCnt <= '0;
			sampleTick <= 1'b0;
		end else begin
			sampleTick <= 1'b0;
			if (sampleCnt == SP_W'(SAMPLE_PERIOD - 1)) begin
				sampleCnt <= '0;
				sampleTick <= 1'b1;
			end else
				sampleCnt <= sampleCnt + 1'b1;
		end
	end

	// Compensation delay after each sample; latest holds the newest finished one
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			compCnt <= '0;
			compDone <= 1'b0;
			latest <= '0;
		end else begin
			compDone <= 1'b0;
			if (sampleTick)
				compCnt <= 7'(COMP_CYCLES - 1); // Done lands COMP_CYCLES after the tick
			else if (compCnt != 7'h0) begin
				compCnt <= compCnt - 1'b1;
				if (compCnt == 7'h1) begin
					compDone <= 1'b1;
					latest <= sensorIn;
				end
			end
		end
	end

	// Decimation: one message per decim samples; zero treated as one
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			decimCnt <= 16'h0;
			sendReq <= 1'b0;
		end else begin
			sendReq <= 1'b0;
			if (trigEn) begin
				decimCnt <= 16'h0;
			end else if (compDone) begin
				if (decimCnt + 16'h1 >= decim) begin
					decimCnt <= 16'h0;
					sendReq <= 1'b1;
				end else
					decimCnt <= decimCnt + 16'h1;
			end
		end
	end

	assign trigRise = trigEn & trigLevel & ~trigPrev;

	// Frame byte for the current index
	always_comb begin
		logic [5:0] p;
		logic [7:0] plen;
		p = 6'h0;
		plen = 8'(({7'h0, select[0]} + {7'h0, select[1]}) * FIELD_LEN);
		curByte = 8'h0;
		case (byteIdx)
			6'd0: curByte = MARKER_BYTE;
			6'd1: curByte = MARKER_BYTE;
			6'd2: curByte = MSG_TYPE;
			6'd3: curByte = plen;
			default: begin
				if (byteIdx >= frameLen - 6'd2)
					curByte = (byteIdx == frameLen - 6'd2) ? sumA : sumB;
				else begin
					p = byteIdx - 6'd4;
					if (select[0] && p < 6'd14) begin
						if (p == 6'd0)
							curByte = ACCEL_CODE;
						else if (p == 6'd1)
							curByte = VEC_SIZE;
						else
							curByte = frame.accel[8'(95 - 8 * (p - 6'd2)) -: 8];
					end else begin
						if (select[0])
							p = p - 6'd14;
						if (p == 6'd0)
							curByte = RATE_CODE;
						else if (p == 6'd1)
							curByte = VEC_SIZE;
						else
							curByte = frame.rate[8'(95 - 8 * (p - 6'd2)) -: 8];
					end
				end
			end
		endcase
	end

	// Message sequencing and checksum
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			busy <= 1'b0;
			byteIdx <= 6'h0;
			frameLen <= 6'h0;
			sumA <= 8'h0;
			sumB <= 8'h0;
			frame <= '0;
		end else if (!busy) begin
			if ((sendReq || trigRise) && select != 2'h0) begin
				busy <= 1'b1;
				byteIdx <= 6'h0;
				sumA <= 8'h0;
				sumB <= 8'h0;
				frame <= latest;
				frameLen <= 6'd6 + (select[0] ? 6'd14 : 6'd0) + (select[1] ? 6'd14 : 6'd0);
			end
		end else if (byteDone) begin
			if (byteIdx < frameLen - 6'd2) begin
				sumA <= mod255(sumA, curByte);
				sumB <= mod255(sumB, mod255(sumA, curByte));
			end
			if (byteIdx == frameLen - 6'd1)
				busy <= 1'b0;
			byteIdx <= byteIdx + 6'h1;
		end
	end

	// 8N1 serial transmitter
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			txState <= TX_IDLE;
			bitCnt <= '0;
			bitIdx <= 3'h0;
			shiftReg <= 8'h0;
			txLine <= 1'b1;
			byteDone <= 1'b0;
		end else begin
			byteDone <= 1'b0;
			case (txState)
				TX_IDLE: begin
					txLine <= 1'b1;
					if (busy && !byteDone) begin
						shiftReg <= curByte;
						txLine <= 1'b0;
						bitCnt <= '0;
						txState <= TX_START;
					end
				end
				TX_START, TX_DATA: begin
					if (bitCnt == BP_W'(BIT_PERIOD - 1)) begin
						bitCnt <= '0;
						if (txState == TX_START) begin
							txLine <= shiftReg[0];
							bitIdx <= 3'h0;
							txState <= TX_DATA;
						end else if (bitIdx == 3'h7) begin
							txLine <= 1'b1;
							txState <= TX_STOP;
						end else begin
							txLine <= shiftReg[bitIdx + 3'h1];
							bitIdx <= bitIdx + 3'h1;
						end
					end else
						bitCnt <= bitCnt + 1'b1;
				end
				TX_STOP: begin
					if (bitCnt == BP_W'(BIT_PERIOD - 1)) begin
						bitCnt <= '0;
						byteDone <= 1'b1;
						txState <= TX_IDLE;
					end else
						bitCnt <= bitCnt + 1'b1;
				end
				default: txState <= TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			serialTxPos <= 1'b1;
			serialTxNeg <= 1'b0;
		end else begin
			serialTxPos <= txLine;
			serialTxNeg <= ~txLine;
		end
	end

	// Validity strobe; in trigger mode it tracks compensation, not transmission
	always_ff @(posedge mclk) begin
		if (sys_rst)
			sample_valid_strobe <= 1'b1;
		else if (trigEn) begin
			if (sampleTick)
				sample_valid_strobe <= 1'b0;
			else if (compDone)
				sample_valid_strobe <= 1'b1;
		end else begin
			if (sampleTick && decimCnt + 16'h1 >= decim)
				sample_valid_strobe <= 1'b0;
			else if (busy && byteDone && byteIdx == frameLen - 6'd1)
				sample_valid_strobe <= 1'b1;
		end
	end
endmodule

// [test/isf_frame_tx_asserts.sv]
// Purpose: Port checks for the frame transmitter
// Assumes: Mode and decimation seen on bus writes
// Notes: Counters replace long repetitions
`timescale 1ns/1ps
module isf_frame_tx_asserts import isf_pkg::*; #(
	parameter int unsigned SAMPLE_PERIOD = SAMPLE_CYCLES,
	parameter int unsigned BIT_PERIOD = BIT_CYCLES
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire isf_bus_t busIn,
	input wire logic [31:0] rdata,
	input wire logic serialTxPos,
	input wire logic serialTxNeg,
	input wire logic sample_valid_strobe,
	input wire logic ext_sample_request_in
);
	logic trig;
	logic seen;
	logic [15:0] decim;
	int lowRun, highRun, lowLen, gap;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			trig <= 1'b0;
			decim <= DECIM_DEFAULT;
		end else if (busIn.wr && busIn.addr == REG_CTRL) begin
			trig <= busIn.wdata[CTRL_TRIG_EN];
		end else if (busIn.wr && busIn.addr == REG_DECIM) begin
			decim <= busIn.wdata[15:0];
		end
	end
	// Run lengths in cycles; the first tick gap after reset is ignored
	always_ff @(posedge mclk) begin
		lowRun <= serialTxPos ? 0 : lowRun + 1;
		highRun <= serialTxPos ? highRun + 1 : 0;
		lowLen <= sample_valid_strobe ? 0 : lowLen + 1;
		gap <= $fell(sample_valid_strobe) ? 1 : gap + 1;
		seen <= !sys_rst && (seen || $fell(sample_valid_strobe));
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	sequence s_trigIdle; $rose(ext_sample_request_in) && trig && highRun >= 64; endsequence
	sequence s_stopDone; serialTxPos && highRun >= BIT_PERIOD; endsequence
	property p_diff; serialTxPos != serialTxNeg; endproperty
	a_diff: assert property (p_diff) else $error("tx pair");
	property p_bit; $rose(serialTxPos) |-> lowRun % BIT_PERIOD == 0; endproperty
	a_bit: assert property (p_bit) else $error("bit length");
	property p_busy; !trig && !serialTxPos |-> !sample_valid_strobe; endproperty
	a_busy: assert property (p_busy) else $error("strobe high in frame");
	property p_rise; !trig && $rose(sample_valid_strobe) |-> s_stopDone; endproperty
	a_rise: assert property (p_rise) else $error("strobe rose early");
	property p_comp; trig && $rose(sample_valid_strobe) |-> lowLen == COMP_CYCLES; endproperty
	a_comp: assert property (p_comp) else $error("strobe width");
	property p_start; s_trigIdle |-> ##[2:12] !serialTxPos; endproperty
	a_start: assert property (p_start) else $error("no start bit");
	property p_tick; seen && $fell(sample_valid_strobe) |-> gap % SAMPLE_PERIOD == 0; endproperty
	a_tick: assert property (p_tick) else $error("tick spacing");
	property p_decim; $past(busIn.rd && busIn.addr == REG_DECIM) |-> rdata == {16'h0, $past(decim)}; endproperty
	a_decim: assert property (p_decim) else $error("decim read");
endmodule

// [test/isf_host_rx.sv]
// Purpose: Host end of the serial link
// Assumes: Line idles high
// Notes: Samples each bit near its middle
`timescale 1ns/1ps
module isf_host_rx #(
	parameter int BP = 4
) (
	input wire logic mclk,
	input wire logic txPos,
	input wire logic sendLevel,
	output logic [7:0] rxByte,
	output logic rxStb,
	output logic rxPos,
	output logic rxNeg
);
	assign rxPos = sendLevel;
	assign rxNeg = !sendLevel;
	initial begin
		rxStb = 0;
		rxByte = 0;
		forever begin
			@(posedge mclk);
			if (!txPos) begin
				repeat (BP / 2) @(posedge mclk);
				for (int i = 0; i < 8; i++) begin
					repeat (BP) @(posedge mclk);
					rxByte[i] <= txPos;
				end
				repeat (BP) @(posedge mclk);
				// A bad stop bit drops the byte
				rxStb <= txPos;
				@(posedge mclk);
				rxStb <= 0;
			end
		end
	end
endmodule

// [test/isf_frame_tx_tb.sv]
// Purpose: Self-checking bench for the frame transmitter
// Assumes: Periods cut to 1000 and 4 cycles, so a frame fits a decimated period
// Notes: Host model decodes the serial line
`timescale 1ns/1ps
module isf_frame_tx_tb import isf_pkg::*;;
	localparam int SP = 1000;
	logic mclk = 0;
	logic sys_rst = 1;
	logic trig = 0;
	logic pps = 0;
	logic lvl = 1;
	isf_bus_t busIn = '0;
	isf_sample_t sensorIn = {96'h37a7c5ac377ba8823f800065, 96'h37a7c5ac377ba8823749539c};
	logic [31:0] rdata;
	logic txPos, txNeg, rxPos, rxNeg, rxLevel, strobe, ppsSeen, hStb;
	logic [7:0] hByte;
	logic [7:0] got[$];
	int bad_count = 0;
	int checks = 0;
	always #10 mclk = ~mclk;
	always @(posedge mclk)
		if (hStb) got.push_back(hByte);
	isf_frame_tx #(.SAMPLE_PERIOD(SP), .BIT_PERIOD(4)) DUT (.mclk(mclk), .sys_rst(sys_rst), .busIn(busIn),
		.rdata(rdata), .sensorIn(sensorIn), .serial_rx_pos(rxPos), .serial_rx_neg(rxNeg), .serialTxPos(txPos),
		.serialTxNeg(txNeg), .rxLevel(rxLevel), .sample_valid_strobe(strobe), .ext_sample_request_in(trig),
		.gps_second_pulse_in(pps), .ppsSeen(ppsSeen));
	isf_host_rx #(.BP(4)) HOST (.mclk(mclk), .txPos(txPos), .sendLevel(lvl), .rxByte(hByte), .rxStb(hStb),
		.rxPos(rxPos), .rxNeg(rxNeg));
	task automatic conclude();
		if (bad_count == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		busIn <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk);
		busIn <= '0;
		@(posedge mclk);
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
		busIn <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge mclk);
		busIn <= '0;
		@(posedge mclk);
		chk("rdata", e, rdata);
	endtask
	task automatic waitv(input logic v, inout int n);
		while (strobe !== v && n < 20000) begin
			@(posedge mclk);
			n++;
		end
	endtask
	// d of zero means trigger mode: one pulse instead of a decimated tick
	task automatic run(input int d, input logic [1:0] sel);
		int n;
		int s1;
		int s2;
		logic [7:0] e[$];
		n = 0;
		s1 = 0;
		s2 = 0;
		e = '{8'ha5, 8'ha5, 8'ha2, 8'(14 * (sel[0] + sel[1]))};
		for (int f = 0; f < 2; f++)
			if (sel[f]) begin
				e.push_back(8'h81 + 8'(f));
				e.push_back(8'h0c);
				for (int i = 11; i >= 0; i--)
					e.push_back(f ? sensorIn.rate[i*8+:8] : sensorIn.accel[i*8+:8]);
			end
		foreach (e[i]) begin
			s1 = (s1 + e[i]) % 255;
			s2 = (s2 + s1) % 255;
		end
		e.push_back(8'(s1));
		e.push_back(8'(s2));
		if (d == 0) begin
			got = {};
			trig <= 1;
			repeat (50) @(posedge mclk);
			trig <= 0;
		end else begin
			repeat (2) begin
				waitv(1, n);
				waitv(0, n);
			end
			n = 0;
			waitv(1, n);
			waitv(0, n);
			got = {};
			chk("period", d * SP, n);
		end
		n = 0;
		while (got.size() < e.size() && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		chk("bytes", e.size(), got.size());
		foreach (e[i])
			chk("frame byte", e[i], got[i]);
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		sys_rst <= 0;
		@(posedge mclk);
		chk("ppsSeen", 0, ppsSeen);
		chk("rxLevel", 1, rxLevel);
		rdchk(REG_CTRL, 32'h6);
		rdchk(REG_DECIM, 32'h4);
		rdchk(REG_FILTER, 32'h2);
		rdchk(REG_RANGE, 32'h0);
		wr(4'hf, 32'hffffffff);
		rdchk(4'hf, 32'h0);
		wr(REG_FILTER, 32'h5);
		wr(REG_RANGE, 32'h65);
		rdchk(REG_FILTER, 32'h5);
		rdchk(REG_RANGE, 32'h65);
		run(4, 2'b11);
		rdchk(REG_STATUS, 32'h22);
		wr(REG_CTRL, 32'h2);
		wr(REG_DECIM, 32'h2);
		run(2, 2'b01);
		wr(REG_DECIM, 32'hffff);
		wr(REG_CTRL, 32'h6);
		repeat (1500) @(posedge mclk);
		got = {};
		trig <= 1;
		repeat (50) @(posedge mclk);
		trig <= 0;
		repeat (600) @(posedge mclk);
		chk("ignored trigger", 0, got.size());
		wr(REG_CTRL, 32'h7);
		run(0, 2'b11);
		pps <= 1;
		repeat (50) @(posedge mclk);
		pps <= 0;
		@(posedge mclk);
		chk("ppsSeen", 1, ppsSeen);
		lvl <= 0;
		repeat (30) @(posedge mclk);
		chk("rxLevel", 0, rxLevel);
		conclude();
	end
	initial begin
		repeat (60000) @(posedge mclk);
		bad_count++;
		conclude();
	end
endmodule
bind isf_frame_tx isf_frame_tx_asserts #(.SAMPLE_PERIOD(SAMPLE_PERIOD), .BIT_PERIOD(BIT_PERIOD)) CHK (.mclk(mclk),
	.sys_rst(sys_rst), .busIn(busIn), .rdata(rdata), .serialTxPos(serialTxPos), .serialTxNeg(serialTxNeg),
	.sample_valid_strobe(sample_valid_strobe), .ext_sample_request_in(ext_sample_request_in));
